// ---- dv/disturbance_recorder_control_assertions.sv ----
// Concurrent checks on the ports of the recorder control block.
// Assumes a bind from the bench top that hands on MS_CYCLES.
`timescale 1ns/1ps
`include "recorder_regs.vh"
module disturbance_recorder_control_assertions
#(
	parameter int MS_CYCLES = 10
)
(
	input wire clk,
	input wire reset,
	input wire read_strobe,
	input wire [31:0] read_data,
	input wire [31:0] sampled_channels,
	input wire [2:0] recorder_status,
	input wire capture_done
);
	localparam int TRIG_MAX = MS_CYCLES + 1;
	localparam int SAMPLE = 5 * MS_CYCLES;
	logic [15:0] gap;
	// Cycles since the channel word last changed; run stays far below wrap
	always @(posedge clk)
		gap <= (reset || $changed(sampled_channels)) ? 16'h0 : gap + 16'h1;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	AST_CONST_CH: assert property (sampled_channels[1:0] == 2'b10)
		else $error("constant channels wrong");
	AST_SAMPLE_GAP: assert property ($changed(sampled_channels)
		|-> gap >= SAMPLE - 2) else $error("channels sampled too soon");
	AST_STATUS_CODE: assert property (recorder_status <= `ST_BAD_CONFIG)
		else $error("status code out of range");
	AST_DONE_PULSE: assert property (capture_done |=> !capture_done)
		else $error("commit pulse too long");
	AST_TRIG_TO_REC: assert property ($fell(recorder_status == `ST_TRIGGERED)
		|-> recorder_status == `ST_REC_STORE) else $error("bad step after trigger");
	AST_TRIG_LEN: assert property ($rose(recorder_status == `ST_TRIGGERED)
		|-> ##[1:TRIG_MAX] recorder_status != `ST_TRIGGERED)
		else $error("triggered state too long");
	AST_STORE_MIN: assert property ($rose(recorder_status == `ST_STORING)
		|-> (recorder_status == `ST_STORING) [*8]) else $error("storing too short");
	AST_READ_IDLE: assert property (!$past(read_strobe) |-> read_data == 32'h0)
		else $error("read data outside its cycle");
	COV_TRIG: cover property ($rose(recorder_status == `ST_TRIGGERED));
	COV_STORE: cover property ($rose(recorder_status == `ST_STORING));
	COV_DONE: cover property (capture_done);
endmodule

// ---- dv/event_source_model.sv ----
// Internal binary event sources and alarm flags facing the recorder.
// Assumes the bench sets the wanted levels; they reach the block registered.
`timescale 1ns/1ps
module event_source_model
(
	input wire clk,
	input wire [24:0] ev,
	input wire [5:0] fl,
	output reg [24:0] event_sources,
	output reg [5:0] flags
);
	initial event_sources = 25'h0000000;
	initial flags = 6'h00;
	// Levels change only on a clock edge, like any internal event source
	always @(posedge clk)
	begin
		event_sources <= ev;
		flags <= fl;
	end
endmodule

// ---- dv/test_disturbance_recorder_control.sv ----
// Self-checking bench for the recorder control block.
// Assumes MS_CYCLES of 10, so one 5 ms sample period is 50 cycles.
`timescale 1ns/1ps
`include "recorder_regs.vh"
module test_disturbance_recorder_control;
	reg clk = 1'b0;
	reg reset = 1'b1;
	reg [7:0] address = 8'h00;
	reg [31:0] write_data = 32'h00000000;
	reg write_strobe = 1'b0;
	reg read_strobe = 1'b0;
	reg [24:0] ev = 25'h0000000;
	reg [5:0] fl = 6'h00;
	wire [24:0] event_sources;
	wire [5:0] flags;
	wire [31:0] read_data;
	wire [31:0] sampled_channels;
	wire [2:0] recorder_status;
	wire capture_done;
	integer err_count = 0;
	integer compares = 0;
	integer cycles = 0;
	disturbance_recorder_control #(.MS_CYCLES(10)) u_dut (.clk(clk),
		.reset(reset), .address(address), .write_data(write_data),
		.write_strobe(write_strobe), .read_strobe(read_strobe),
		.read_data(read_data), .event_sources(event_sources),
		.phase_order_flag(flags[0]), .internal_fault(flags[1]),
		.time_sync_lost_flag(flags[2]), .open_button(flags[3]),
		.close_button(flags[4]), .freq_functions_enabled(flags[5]),
		.sampled_channels(sampled_channels),
		.recorder_status(recorder_status), .capture_done(capture_done));
	event_source_model u_src (.clk(clk), .ev(ev), .fl(fl),
		.event_sources(event_sources), .flags(flags));
	initial forever #4 clk = ~clk;
	always @(posedge clk)
	begin
		cycles = cycles + 1;
		if (cycles == 20000)
		begin
			err_count = err_count + 1;
			results;
		end
	end
	task chk(input [31:0] got, input [31:0] exp);
		compares = compares + 1;
		if (got !== exp)
		begin
			err_count = err_count + 1;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input [7:0] a, input [31:0] v);
		@(posedge clk);
		address <= a;
		write_data <= v;
		write_strobe <= 1'b1;
		@(posedge clk);
		write_strobe <= 1'b0;
	endtask
	task rc(input [7:0] a, input [31:0] exp);
		@(posedge clk);
		address <= a;
		read_strobe <= 1'b1;
		@(posedge clk);
		read_strobe <= 1'b0;
		#1;
		chk(read_data, exp);
	endtask
	task pause(input integer n);
		repeat (n) @(posedge clk);
	endtask
	// Bounded wait for one commit, then the record count
	task done_wait(input [31:0] count);
		integer i;
		i = 0;
		while (i < 3000 && capture_done !== 1'b1)
		begin
			@(posedge clk);
			#1;
			i = i + 1;
		end
		chk({31'h0, capture_done}, 32'h1);
		rc(`REG_COUNT, count);
	endtask
	task clear(input [7:0] a, input [31:0] v, input [31:0] n, input [31:0] id);
		wr(a, v);
		pause(20);
		rc(`REG_COUNT, n);
		rc(`REG_NEWEST_ID, id);
	endtask
	task results;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		pause(12);
		reset <= 1'b0;
		pause(120);
		rc(`REG_CONTROL, 32'h00000001);
		rc(`REG_LENGTH, 32'h000003E8);
		rc(`REG_LEAD, 32'h000000C8);
		rc(`REG_COUNT, 32'h00000000);
		rc(8'h3C, 32'h00000000);
		wr(`REG_LENGTH, 32'h00000064);
		wr(`REG_LEAD, 32'h00000032);
		pause(120);
		rc(`REG_CAPACITY, 32'h00000064);
		rc(`REG_LONGEST, 32'h0007A120);
		rc(`REG_LEAD_MAX, 32'h00007530);
		wr(`REG_CONTROL, 32'h0000000D);
		pause(120);
		rc(`REG_LONGEST, 32'h001B7740);
		// Disabled recorder must drop a manual trigger
		wr(`REG_CONTROL, 32'h00000000);
		pause(120);
		wr(`REG_COMMAND, 32'h00000001);
		pause(700);
		rc(`REG_COUNT, 32'h00000000);
		wr(`REG_CONTROL, 32'h00000001);
		pause(120);
		wr(`REG_COMMAND, 32'h00000001);
		rc(`REG_COMMAND, 32'h00000000);
		done_wait(32'h1);
		fl <= 6'h33;
		pause(120);
		rc(`REG_CHANNELS, 32'h0000006E);
		fl <= 6'h0C;
		ev <= 25'h1000001;
		pause(120);
		rc(`REG_CHANNELS, 32'h800000B2);
		ev <= 25'h0000000;
		wr(`REG_TRIG_MASK, 32'h000000A0);
		pause(120);
		ev <= 25'h0000001;
		done_wait(32'h2);
		wr(`REG_TRIG_MASK, 32'h00000000);
		wr(`REG_COMMAND, 32'h00000001);
		done_wait(32'h3);
		clear(`REG_CLEAR_INDEX, 32'h2, 32'h2, 32'h2);
		clear(`REG_COMMAND, 32'h8, 32'h1, 32'h2);
		wr(`REG_COMMAND, 32'h00000001);
		done_wait(32'h2);
		clear(`REG_COMMAND, 32'h4, 32'h1, 32'h2);
		clear(`REG_CLEAR_INDEX, 32'h9, 32'h1, 32'h2);
		// Long settings shrink capacity to one while a short capture runs
		wr(`REG_COMMAND, 32'h00000001);
		pause(20);
		wr(`REG_LENGTH, 32'h0007A120);
		wr(`REG_LEAD, 32'h00007530);
		done_wait(32'h1);
		rc(`REG_NEWEST_ID, 32'h00000004);
		rc(`REG_CAPACITY, 32'h00000001);
		wr(`REG_CONTROL, 32'h00000003);
		rc(`REG_STATUS, 32'h00000004);
		wr(`REG_COMMAND, 32'h00000001);
		rc(`REG_STATUS, 32'h00000004);
		wr(`REG_LEAD, 32'h00007531);
		rc(`REG_STATUS, 32'h00000005);
		clear(`REG_COMMAND, 32'h2, 32'h0, 32'h0);
		results;
	end
endmodule
bind disturbance_recorder_control disturbance_recorder_control_assertions
	#(.MS_CYCLES(MS_CYCLES)) u_chk (.clk(clk), .reset(reset),
	.read_strobe(read_strobe), .read_data(read_data),
	.sampled_channels(sampled_channels),
	.recorder_status(recorder_status), .capture_done(capture_done));

// ---- src/disturbance_recorder_control.v ----
// Control and triggering logic of a disturbance recorder: binary channel
// sampling, trigger selection, record bookkeeping, clear commands, limits.
// Assumes one 125 MHz clock, synchronous inputs and a single-cycle
// register port whose read data appear in the cycle after the read strobe.
//
// Functional notes
// - Binary channels are sampled every 5 ms regardless of analog rate.
// - Capture starts on manual command or on a selected active source.
// - Any binary channel may be a trigger source; several at once.
// - Never more than 100 stored recordings.
// - Enable setting gates recording; disabled means no capture starts.
// - Status is ready, triggered, rec+store, storing, full or bad config.
// - Writing index N to clear-index deletes the Nth stored recording.
// - Manual trigger fires once and reads back idle by itself.
// - Clear-all deletes every recording, count becomes zero.
// - Clear-newest deletes only the most recent recording.
// - Clear-oldest deletes only the earliest recording.
// - Count of recordings held is reported, 0 to 100.
// - Capacity from current settings is reported, capped at 100.
// - Longest allowed recording is reported, 0 to 1800 s.
// - Largest allowed pre-trigger span is reported.
// - Two constant channels, one always 0 and one always 1.
// - Phase-order channel is 0 for A-B-C and 1 for A-C-B.
// - Internal-fault channel is set while a self fault exists.
// - Time-sync channel is set while time synchronization is lost.
// - Button channel is set while front open or close is pressed.
// - Frequency channel is set while frequency functions are enabled.
// - When full, replace the oldest or refuse, per storage mode.
// - Each capture includes a pre-trigger span, default 0.2 s.
`timescale 1ns/1ps
`include "recorder_regs.vh"

module disturbance_recorder_control
#(
	parameter [31:0] MS_CYCLES = `CLK_KHZ
)
(
	input wire clk,
	input wire reset,
	input wire [7:0] address,
	input wire [31:0] write_data,
	input wire write_strobe,
	input wire read_strobe,
	output reg [31:0] read_data,
	input wire [24:0] event_sources,
	input wire phase_order_flag,
	input wire internal_fault,
	input wire time_sync_lost_flag,
	input wire open_button,
	input wire close_button,
	input wire freq_functions_enabled,
	output reg [31:0] sampled_channels,
	output reg [2:0] recorder_status,
	output reg capture_done
);

	localparam CAP_IDLE = 2'h0;
	localparam CAP_TRIG = 2'h1;
	localparam CAP_REC = 2'h2;
	localparam CAP_STORE = 2'h3;
	localparam MG_IDLE = 1'b0;
	localparam MG_SHIFT = 1'b1;

	// Settings
	reg enable;
	reg keep_old;
	reg [1:0] rate_sel;
	reg [20:0] length_ms;
	reg [14:0] lead_ms;
	reg [31:0] trig_mask;

	// Timebase
	reg [31:0] ms_count;
	reg ms_tick;
	reg [2:0] sample_ms;
	reg sample_tick;

	// Capture sequencing
	reg [1:0] cap_state;
	reg [20:0] post_ms;
	reg [7:0] store_count;
	reg auto_hit;
	reg commit_req;

	// Record store, oldest at index 0
	reg [15:0] rec_id [0:99];
	reg [6:0] rec_count;
	reg [15:0] next_id;
	reg mg_state;
	reg [6:0] shift_ptr;
	reg add_after;

	// Limits
	reg [31:0] calc_rem;
	reg [6:0] calc_n;
	reg [6:0] capacity;
	reg [20:0] longest_ms;
	reg [20:0] lead_max_ms;

	wire wr_ctl = write_strobe && address == `REG_CONTROL;
	wire wr_cmd = write_strobe && address == `REG_COMMAND;
	wire wr_idx = write_strobe && address == `REG_CLEAR_INDEX;
	wire manual_trig = wr_cmd && write_data[`CMD_TRIG];
	wire clr_all = wr_cmd && write_data[`CMD_CLR_ALL];
	wire clr_newest = wr_cmd && write_data[`CMD_CLR_NEWEST];
	wire clr_oldest = wr_cmd && write_data[`CMD_CLR_OLDEST];

	wire [31:0] channels;
	wire [1:0] shift = 2'h3 - rate_sel;
	wire [31:0] rec_units = {11'h000, length_ms} << shift;
	wire [31:0] budget_ms = `MEM_UNITS >> shift;
	wire full = rec_count >= capacity;
	wire bad_config;
	wire trig_ok;

	// Channel vector: constants, dedicated flags, then the event sources
	assign channels[0] = 1'b0;
	assign channels[1] = 1'b1;
	assign channels[2] = phase_order_flag;
	assign channels[3] = internal_fault;
	assign channels[4] = time_sync_lost_flag;
	assign channels[5] = open_button | close_button;
	assign channels[6] = freq_functions_enabled;
	assign channels[31:7] = event_sources;

	assign bad_config = length_ms < `MIN_LENGTH_MS ||
		length_ms > longest_ms || {6'h00, lead_ms} > length_ms ||
		lead_ms > `MAX_LEAD_MS || capacity == 7'h00;

	// Refused while disabled, misconfigured, busy, or full in keep mode
	assign trig_ok = enable && !bad_config && cap_state == CAP_IDLE &&
		!(full && keep_old);

	always @(posedge clk)
	begin
		if (reset)
		begin
			enable <= `RST_ENABLE;
			keep_old <= `RST_KEEP_OLD;
			rate_sel <= `RST_RATE;
			length_ms <= `RST_LENGTH_MS;
			lead_ms <= `RST_LEAD_MS;
			trig_mask <= `RST_TRIG_MASK;
		end
		else if (write_strobe)
		begin
			if (wr_ctl)
			begin
				enable <= write_data[`CTL_ENABLE];
				keep_old <= write_data[`CTL_KEEP_OLD];
				rate_sel <= write_data[`CTL_RATE_HI:`CTL_RATE_LO];
			end
			if (address == `REG_LENGTH)
				length_ms <= write_data[20:0];
			if (address == `REG_LEAD)
				lead_ms <= write_data[14:0];
			if (address == `REG_TRIG_MASK)
				trig_mask <= write_data;
		end
	end

	// Millisecond enable, then one sample enable every five of them
	always @(posedge clk)
	begin
		if (reset)
		begin
			ms_count <= 32'h00000000;
			ms_tick <= 1'b0;
			sample_ms <= 3'h0;
			sample_tick <= 1'b0;
		end
		else
		begin
			ms_tick <= 1'b0;
			sample_tick <= 1'b0;
			if (ms_count >= MS_CYCLES - 32'h00000001)
			begin
				ms_count <= 32'h00000000;
				ms_tick <= 1'b1;
				if (sample_ms == `BIN_SAMPLE_MS - 3'h1)
				begin
					sample_ms <= 3'h0;
					sample_tick <= 1'b1;
				end
				else
					sample_ms <= sample_ms + 3'h1;
			end
			else
				ms_count <= ms_count + 32'h00000001;
		end
	end

	// Sources trigger when they become active between two samples
	always @(posedge clk)
	begin
		if (reset)
		begin
			sampled_channels <= 32'h00000001 << 1;
			auto_hit <= 1'b0;
		end
		else
		begin
			auto_hit <= 1'b0;
			if (sample_tick)
			begin
				sampled_channels <= channels;
				auto_hit <= |(channels & ~sampled_channels &
					trig_mask);
			end
		end
	end

	// Capture sequence; the pre-trigger span is already held in history,
	// so only the part after the trigger is timed here
	always @(posedge clk)
	begin
		if (reset)
		begin
			cap_state <= CAP_IDLE;
			post_ms <= 21'h000000;
			store_count <= 8'h00;
			commit_req <= 1'b0;
			capture_done <= 1'b0;
		end
		else
		begin
			commit_req <= 1'b0;
			capture_done <= 1'b0;
			case (cap_state)
			CAP_IDLE:
				if (trig_ok && (manual_trig || auto_hit))
				begin
					cap_state <= CAP_TRIG;
					post_ms <= length_ms - {6'h00, lead_ms};
				end
			CAP_TRIG:
				if (ms_tick)
					cap_state <= CAP_REC;
			CAP_REC:
				if (ms_tick)
				begin
					if (post_ms <= 21'h000001)
					begin
						cap_state <= CAP_STORE;
						store_count <= `STORE_CYCLES;
					end
					else
						post_ms <= post_ms - 21'h000001;
				end
			CAP_STORE:
				if (store_count != 8'h00)
					store_count <= store_count - 8'h01;
				else if (mg_state == MG_IDLE && !commit_req && !wr_cmd &&
					!wr_idx)
				begin
					commit_req <= 1'b1;
					capture_done <= 1'b1;
					cap_state <= CAP_IDLE;
				end
			default:
				cap_state <= CAP_IDLE;
			endcase
		end
	end

	// Record bookkeeping. Deleting from the middle closes the gap one
	// entry per cycle; clear commands that arrive meanwhile are ignored.
	always @(posedge clk)
	begin
		if (reset)
		begin
			rec_count <= 7'h00;
			next_id <= 16'h0000;
			mg_state <= MG_IDLE;
			shift_ptr <= 7'h00;
			add_after <= 1'b0;
		end
		else
		begin
			case (mg_state)
			MG_IDLE:
				if (clr_all)
					rec_count <= 7'h00;
				else if (commit_req)
				begin
					if (rec_count < capacity)
					begin
						rec_id[rec_count] <= next_id;
						rec_count <= rec_count + 7'h01;
						next_id <= next_id + 16'h0001;
					end
					else if (!keep_old)
					begin
						shift_ptr <= 7'h00;
						add_after <= 1'b1;
						mg_state <= MG_SHIFT;
					end
				end
				else if (clr_newest && rec_count != 7'h00)
					rec_count <= rec_count - 7'h01;
				else if (clr_oldest && rec_count != 7'h00)
				begin
					shift_ptr <= 7'h00;
					add_after <= 1'b0;
					mg_state <= MG_SHIFT;
				end
				else if (wr_idx && write_data != 32'h00000000 &&
					write_data <= {25'h0000000, rec_count})
				begin
					shift_ptr <= write_data[6:0] - 7'h01;
					add_after <= 1'b0;
					mg_state <= MG_SHIFT;
				end
			MG_SHIFT:
				if (shift_ptr + 7'h01 >= rec_count)
				begin
					if (add_after)
					begin
						rec_id[rec_count - 7'h01] <= next_id;
						next_id <= next_id + 16'h0001;
					end
					else
						rec_count <= rec_count - 7'h01;
					add_after <= 1'b0;
					mg_state <= MG_IDLE;
				end
				else
				begin
					rec_id[shift_ptr] <= rec_id[shift_ptr + 7'h01];
					shift_ptr <= shift_ptr + 7'h01;
				end
			default:
				mg_state <= MG_IDLE;
			endcase
		end
	end

	// Capacity by repeated subtraction; restarts after each result, so a
	// settings change is reflected within about two hundred cycles
	always @(posedge clk)
	begin
		if (reset)
		begin
			calc_rem <= `MEM_UNITS;
			calc_n <= 7'h00;
			capacity <= 7'h00;
		end
		else if (calc_rem >= rec_units && rec_units != 32'h00000000 &&
			calc_n < `MAX_RECORDS)
		begin
			calc_rem <= calc_rem - rec_units;
			calc_n <= calc_n + 7'h01;
		end
		else
		begin
			capacity <= calc_n;
			calc_rem <= `MEM_UNITS;
			calc_n <= 7'h00;
		end
	end

	always @(posedge clk)
	begin
		if (reset)
		begin
			longest_ms <= 21'h000000;
			lead_max_ms <= 21'h000000;
		end
		else
		begin
			if (budget_ms > {11'h000, `MAX_LENGTH_MS})
				longest_ms <= `MAX_LENGTH_MS;
			else
				longest_ms <= budget_ms[20:0];
			if (longest_ms < {6'h00, `MAX_LEAD_MS})
				lead_max_ms <= longest_ms;
			else
				lead_max_ms <= {6'h00, `MAX_LEAD_MS};
		end
	end

	always @(posedge clk)
	begin
		if (reset)
			recorder_status <= `ST_READY;
		else if (bad_config)
			recorder_status <= `ST_BAD_CONFIG;
		else if (cap_state == CAP_IDLE && full && keep_old)
			recorder_status <= `ST_FULL;
		else
			recorder_status <= {1'b0, cap_state};
	end

	// Command register reads zero: commands return to idle by themselves
	always @(posedge clk)
	begin
		if (reset || !read_strobe)
			read_data <= 32'h00000000;
		else
			case (address)
			`REG_CONTROL:
				read_data <= {28'h0000000, rate_sel, keep_old, enable};
			`REG_LENGTH:
				read_data <= {11'h000, length_ms};
			`REG_LEAD:
				read_data <= {17'h00000, lead_ms};
			`REG_TRIG_MASK:
				read_data <= trig_mask;
			`REG_STATUS:
				read_data <= {23'h000000, mg_state, 5'h00, recorder_status};
			`REG_COUNT:
				read_data <= {25'h0000000, rec_count};
			`REG_CAPACITY:
				read_data <= {25'h0000000, capacity};
			`REG_LONGEST:
				read_data <= {11'h000, longest_ms};
			`REG_LEAD_MAX:
				read_data <= {11'h000, lead_max_ms};
			`REG_CHANNELS:
				read_data <= sampled_channels;
			`REG_NEWEST_ID:
				read_data <= (rec_count == 7'h00) ? 32'h00000000 :
					{16'h0000, rec_id[rec_count - 7'h01]};
			default:
				read_data <= 32'h00000000;
			endcase
	end

endmodule

// ---- src/recorder_regs.vh ----
// Register map, field positions, reset values and timing counts for the
// disturbance recorder control block. Definitions only.
`ifndef RECORDER_REGS_VH
`define RECORDER_REGS_VH

// Byte offsets on the 8-bit register address
`define REG_CONTROL 8'h00
`define REG_LENGTH 8'h04
`define REG_LEAD 8'h08
`define REG_TRIG_MASK 8'h0C
`define REG_COMMAND 8'h10
`define REG_CLEAR_INDEX 8'h14
`define REG_STATUS 8'h18
`define REG_COUNT 8'h1C
`define REG_CAPACITY 8'h20
`define REG_LONGEST 8'h24
`define REG_LEAD_MAX 8'h28
`define REG_CHANNELS 8'h2C
`define REG_NEWEST_ID 8'h30

// Control register fields
`define CTL_ENABLE 0
`define CTL_KEEP_OLD 1
`define CTL_RATE_LO 2
`define CTL_RATE_HI 3

// Command register fields (self clearing, read as zero)
`define CMD_TRIG 0
`define CMD_CLR_ALL 1
`define CMD_CLR_NEWEST 2
`define CMD_CLR_OLDEST 3

// Reset values
`define RST_ENABLE 1'b1
`define RST_KEEP_OLD 1'b0
`define RST_RATE 2'h0
`define RST_LENGTH_MS 21'h0003E8
`define RST_LEAD_MS 15'h00C8
`define RST_TRIG_MASK 32'h00000000

// Limits, in records and milliseconds
`define MAX_RECORDS 7'h64
`define MIN_LENGTH_MS 21'h000064
`define MAX_LENGTH_MS 21'h1B7740
`define MAX_LEAD_MS 15'h7530

// Status codes
`define ST_READY 3'h0
`define ST_TRIGGERED 3'h1
`define ST_REC_STORE 3'h2
`define ST_STORING 3'h3
`define ST_FULL 3'h4
`define ST_BAD_CONFIG 3'h5

// Timing
`define CLK_KHZ 32'h0001E848
`define BIN_SAMPLE_MS 3'h5
`define STORE_CYCLES 8'h10
`define MEM_UNITS 32'h003D0900

`endif
